// [design/olr_top.sv]
module olr_top #(
    parameter logic [6:0] SLAVE_ADDR = olr_pkg::OLR_SLAVE_ADDR
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic [11:0]      otg_volt_code,
    output logic [6:0]       otg_curr_code,
    output logic [14:0]      otg_volt_mv,
    output logic [12:0]      otg_curr_ma,
    output logic             write_rejected
);

    // ==========================================================
    // port state
    // ==========================================================
    olr_pkg::olr_state_t state_reg, state_next;   // protocol position
    olr_pkg::olr_state_t ret_reg,   ret_next;     // state after our ack
    logic [3:0]  cnt_reg,     cnt_next;           // bit edges in byte
    logic [7:0]  sh_reg,      sh_next;            // receive shifter
    logic [7:0]  tx_reg,      tx_next;            // transmit shifter
    logic [7:0]  cmd_reg,     cmd_next;           // selected command
    logic [7:0]  lo_reg,      lo_next;            // received low byte
    logic [15:0] rd_word_reg, rd_word_next;       // word being read
    logic        hi_reg,      hi_next;            // sending high byte
    logic        hack_reg,    hack_next;          // host acked last byte
    logic        drive_reg,   drive_next;         // pulling sda low
    logic        wr_stb_reg,  wr_stb_next;        // write pulse to bank
    logic [15:0] wdata_reg,   wdata_next;         // word to bank
    logic        scl_q;                           // scl one cycle ago
    logic        sda_q;                           // sda one cycle ago

    olr_bus_if bus ();                            // link to the bank

    // ==========================================================
    // line events
    // ==========================================================
    wire scl_rise  = scl_in && !scl_q;
    wire scl_fall  = !scl_in && scl_q;
    wire start_cnd = scl_in && scl_q && sda_q && !sda_in;   // sda falls while scl high
    wire stop_cnd  = scl_in && scl_q && !sda_q && sda_in;   // sda rises while scl high
    wire byte_full = (cnt_reg == olr_pkg::OLR_BYTE_BITS);
    wire addr_hit  = (sh_reg[7:1] == SLAVE_ADDR);
    wire rx_state  = (state_reg == olr_pkg::OLR_ADDR) || (state_reg == olr_pkg::OLR_CMD)
                  || (state_reg == olr_pkg::OLR_WR_LO) || (state_reg == olr_pkg::OLR_WR_HI);

    // ==========================================================
    // protocol next state
    // ==========================================================
    always_comb begin
        state_next   = state_reg;
        ret_next     = ret_reg;
        cnt_next     = cnt_reg;
        sh_next      = sh_reg;
        tx_next      = tx_reg;
        cmd_next     = cmd_reg;
        lo_next      = lo_reg;
        rd_word_next = rd_word_reg;
        hi_next      = hi_reg;
        hack_next    = hack_reg;
        drive_next   = drive_reg;
        wdata_next   = wdata_reg;
        wr_stb_next  = 1'b0;
        if (start_cnd) begin
            // start or repeated start: listen for the address
            state_next = olr_pkg::OLR_ADDR;
            cnt_next   = 4'h0;
            drive_next = 1'b0;
        end else if (stop_cnd) begin
            // stop always frees the line
            state_next = olr_pkg::OLR_IDLE;
            drive_next = 1'b0;
        end else if (rx_state) begin
            if (scl_rise) begin
                // sample one data bit, msb first
                sh_next  = {sh_reg[6:0], sda_in};
                cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
                cnt_next   = 4'h0;
                drive_next = 1'b1;
                state_next = olr_pkg::OLR_ACK;
                if (state_reg == olr_pkg::OLR_ADDR) begin
                    if (!addr_hit) begin
                        // not our address: stay off the line
                        drive_next = 1'b0;
                        state_next = olr_pkg::OLR_IDLE;
                    end else if (sh_reg[0]) begin
                        // read: freeze the word of the selected command
                        rd_word_next = bus.rdata;
                        hi_next      = 1'b0;
                        ret_next     = olr_pkg::OLR_RD;
                    end else begin
                        ret_next = olr_pkg::OLR_CMD;
                    end
                end else if (state_reg == olr_pkg::OLR_CMD) begin
                    cmd_next = sh_reg;
                    ret_next = olr_pkg::OLR_WR_LO;
                end else if (state_reg == olr_pkg::OLR_WR_LO) begin
                    lo_next  = sh_reg;                         // low byte comes first
                    ret_next = olr_pkg::OLR_WR_HI;
                end else begin
                    // high byte completes the word
                    wdata_next  = {sh_reg, lo_reg};
                    wr_stb_next = 1'b1;
                    ret_next    = olr_pkg::OLR_IDLE;
                end
            end
        end else if (state_reg == olr_pkg::OLR_ACK) begin
            if (scl_fall) begin
                // end of our ack bit
                state_next = ret_reg;
                cnt_next   = 4'h0;
                drive_next = 1'b0;
                if (ret_reg == olr_pkg::OLR_RD) begin
                    tx_next    = rd_word_reg[7:0];
                    drive_next = !rd_word_reg[7];
                end
            end
        end else if (state_reg == olr_pkg::OLR_RD) begin
            if (scl_rise) begin
                cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall) begin
                if (byte_full) begin
                    // release for the host's ack
                    drive_next = 1'b0;
                    state_next = olr_pkg::OLR_HACK;
                end else begin
                    tx_next    = {tx_reg[6:0], 1'b0};
                    drive_next = !tx_reg[6];
                end
            end
        end else if (state_reg == olr_pkg::OLR_HACK) begin
            if (scl_rise) begin
                hack_next = !sda_in;
            end else if (scl_fall) begin
                cnt_next = 4'h0;
                if (hack_reg && !hi_reg) begin
                    // acked low byte: send high byte
                    hi_next    = 1'b1;
                    tx_next    = rd_word_reg[15:8];
                    drive_next = !rd_word_reg[15];
                    state_next = olr_pkg::OLR_RD;
                end else begin
                    state_next = olr_pkg::OLR_IDLE;
                end
            end
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    // line history
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // protocol control
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg  <= olr_pkg::OLR_IDLE;
            ret_reg    <= olr_pkg::OLR_IDLE;
            cnt_reg    <= 4'h0;
            hi_reg     <= 1'b0;
            hack_reg   <= 1'b0;
            drive_reg  <= 1'b0;
            wr_stb_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            ret_reg    <= ret_next;
            cnt_reg    <= cnt_next;
            hi_reg     <= hi_next;
            hack_reg   <= hack_next;
            drive_reg  <= drive_next;
            wr_stb_reg <= wr_stb_next;
        end
    end

    // protocol data
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sh_reg      <= 8'h00;
            tx_reg      <= 8'h00;
            cmd_reg     <= 8'h00;
            lo_reg      <= 8'h00;
            rd_word_reg <= 16'h0000;
            wdata_reg   <= 16'h0000;
        end else begin
            sh_reg      <= sh_next;
            tx_reg      <= tx_next;
            cmd_reg     <= cmd_next;
            lo_reg      <= lo_next;
            rd_word_reg <= rd_word_next;
            wdata_reg   <= wdata_next;
        end
    end

    // ==========================================================
    // bank
    // ==========================================================
    assign bus.wr_stb = wr_stb_reg;
    assign bus.cmd    = cmd_reg;
    assign bus.wdata  = wdata_reg;

    olr_limit_bank u_bank (
        .clk       (clk),
        .rstn      (rstn),
        .bus       (bus.bank),
        .volt_code (otg_volt_code),
        .curr_code (otg_curr_code),
        .volt_mv   (otg_volt_mv),
        .curr_ma   (otg_curr_ma),
        .reject    (write_rejected)
    );

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_reg;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_pull_low: assert property (state_reg == olr_pkg::OLR_ACK |-> sda_oe)
        else $error("ack bit not driven low");
    a_write_one_pulse: assert property (wr_stb_reg |=> !wr_stb_reg)
        else $error("write strobe longer than one cycle");
    a_cmd_held_write: assert property (wr_stb_reg |-> $stable(cmd_reg))
        else $error("command changed at write strobe");
    a_stop_frees_line: assert property (stop_cnd |=> !sda_oe && state_reg == olr_pkg::OLR_IDLE)
        else $error("line held after stop");

    c_word_write: cover property (wr_stb_reg && cmd_reg == olr_pkg::OLR_CMD_VOLT);

endmodule

// [design/olr_pkg.sv]
package olr_pkg;

    // ==========================================================
    // register map
    // ==========================================================
    localparam logic [7:0]  OLR_CMD_VOLT      = 8'h3b;   // output voltage limit command
    localparam logic [7:0]  OLR_CMD_CURR      = 8'h3c;   // output current limit command
    localparam logic [15:0] OLR_VOLT_RST      = 16'h09c4; // voltage limit after reset
    localparam logic [15:0] OLR_CURR_RST      = 16'h3c00; // current limit after reset
    localparam logic [15:0] OLR_UNMAPPED_RD   = 16'h0000; // answer for other commands

    // ==========================================================
    // field layout
    // ==========================================================
    localparam int          OLR_VFLD_LSB      = 2;        // voltage code low bit
    localparam int          OLR_VFLD_MSB      = 13;       // voltage code high bit
    localparam int          OLR_IFLD_LSB      = 8;        // current code low bit
    localparam int          OLR_IFLD_MSB      = 14;       // current code high bit
    localparam logic [15:0] OLR_VOLT_BAD_MASK = 16'hc000; // ones here spoil a voltage write
    localparam logic [15:0] OLR_CURR_BAD_MASK = 16'h8000; // ones here spoil a current write
    localparam logic [15:0] OLR_VOLT_KEEP     = 16'h3ffc; // bits that a voltage write stores
    localparam logic [15:0] OLR_CURR_KEEP     = 16'h7f00; // bits that a current write stores

    // ==========================================================
    // weights and limits
    // ==========================================================
    localparam int          OLR_VSTEP_MV      = 8;        // weight of voltage code lsb
    localparam int          OLR_ISTEP_MA      = 50;       // weight of current code lsb
    localparam int          OLR_VMIN_MV       = 3000;     // lowest accepted voltage
    localparam int          OLR_VMAX_MV       = 24000;    // highest accepted voltage

    // ==========================================================
    // serial port
    // ==========================================================
    localparam logic [6:0]  OLR_SLAVE_ADDR    = 7'h2a;    // default bus address, arbitrary
    localparam logic [3:0]  OLR_BYTE_BITS     = 4'h8;     // bits in one byte

    // serial port states
    typedef enum logic [2:0] {
        OLR_IDLE  = 3'b000,
        OLR_ADDR  = 3'b001,
        OLR_CMD   = 3'b010,
        OLR_WR_LO = 3'b011,
        OLR_WR_HI = 3'b100,
        OLR_ACK   = 3'b101,
        OLR_RD    = 3'b110,
        OLR_HACK  = 3'b111
    } olr_state_t;

    // voltage code to millivolts
    function automatic logic [14:0] olr_volt_mv(input logic [11:0] code);
        return 15'(int'(code) * OLR_VSTEP_MV);
    endfunction

    // current code to milliamps
    function automatic logic [12:0] olr_curr_ma(input logic [6:0] code);
        return 13'(int'(code) * OLR_ISTEP_MA);
    endfunction

endpackage

// [design/olr_bus_if.sv]
// word access between the serial port and the register bank
interface olr_bus_if;
    logic        wr_stb;  // one-cycle write request
    logic [7:0]  cmd;     // selected command code
    logic [15:0] wdata;   // word to write
    logic [15:0] rdata;   // word at the selected command

    modport port (output wr_stb, output cmd, output wdata, input rdata);
    modport bank (input wr_stb, input cmd, input wdata, output rdata);
endinterface

// [design/olr_limit_bank.sv]
module olr_limit_bank (
    input  wire logic        clk,
    input  wire logic        rstn,
    olr_bus_if.bank          bus,
    output logic [11:0]      volt_code,
    output logic [6:0]       curr_code,
    output logic [14:0]      volt_mv,
    output logic [12:0]      curr_ma,
    output logic             reject
);

    // ==========================================================
    // storage
    // ==========================================================
    logic [15:0] volt_reg;      // voltage limit word
    logic [15:0] curr_reg;      // current limit word
    logic [14:0] volt_mv_reg;   // decoded voltage
    logic [12:0] curr_ma_reg;   // decoded current
    logic        reject_reg;    // one-cycle pulse after a refused write

    // ==========================================================
    // write checks
    // ==========================================================
    wire         sel_v     = bus.wr_stb && (bus.cmd == olr_pkg::OLR_CMD_VOLT);
    wire         sel_i     = bus.wr_stb && (bus.cmd == olr_pkg::OLR_CMD_CURR);
    wire         v_bad     = |(bus.wdata & olr_pkg::OLR_VOLT_BAD_MASK);
    wire         i_bad     = |(bus.wdata & olr_pkg::OLR_CURR_BAD_MASK);
    wire [14:0]  v_new_mv  = olr_pkg::olr_volt_mv(bus.wdata[olr_pkg::OLR_VFLD_MSB:olr_pkg::OLR_VFLD_LSB]);
    wire         v_in_rng  = (v_new_mv >= 15'(olr_pkg::OLR_VMIN_MV))
                          && (v_new_mv <= 15'(olr_pkg::OLR_VMAX_MV));
    wire         v_accept  = sel_v && !v_bad && v_in_rng;
    wire         i_accept  = sel_i && !i_bad;
    // low reserved bits are dropped, not stored
    wire [15:0]  volt_next = v_accept ? (bus.wdata & olr_pkg::OLR_VOLT_KEEP) : volt_reg;
    wire [15:0]  curr_next = i_accept ? (bus.wdata & olr_pkg::OLR_CURR_KEEP) : curr_reg;
    wire         reject_next = (sel_v && !v_accept) || (sel_i && !i_accept);

    // read mux, other commands read zero
    assign bus.rdata = (bus.cmd == olr_pkg::OLR_CMD_VOLT) ? volt_reg :
                       (bus.cmd == olr_pkg::OLR_CMD_CURR) ? curr_reg :
                       olr_pkg::OLR_UNMAPPED_RD;

    // ==========================================================
    // registers
    // ==========================================================
    // words and their decoded values update together
    always_ff @(posedge clk) begin
        if (!rstn) begin
            volt_reg    <= olr_pkg::OLR_VOLT_RST;
            curr_reg    <= olr_pkg::OLR_CURR_RST;
            volt_mv_reg <= olr_pkg::olr_volt_mv(olr_pkg::OLR_VOLT_RST[olr_pkg::OLR_VFLD_MSB:olr_pkg::OLR_VFLD_LSB]);
            curr_ma_reg <= olr_pkg::olr_curr_ma(olr_pkg::OLR_CURR_RST[olr_pkg::OLR_IFLD_MSB:olr_pkg::OLR_IFLD_LSB]);
            reject_reg  <= 1'b0;
        end else begin
            volt_reg    <= volt_next;
            curr_reg    <= curr_next;
            volt_mv_reg <= olr_pkg::olr_volt_mv(volt_next[olr_pkg::OLR_VFLD_MSB:olr_pkg::OLR_VFLD_LSB]);
            curr_ma_reg <= olr_pkg::olr_curr_ma(curr_next[olr_pkg::OLR_IFLD_MSB:olr_pkg::OLR_IFLD_LSB]);
            reject_reg  <= reject_next;
        end
    end

    assign volt_code = volt_reg[olr_pkg::OLR_VFLD_MSB:olr_pkg::OLR_VFLD_LSB];
    assign curr_code = curr_reg[olr_pkg::OLR_IFLD_MSB:olr_pkg::OLR_IFLD_LSB];
    assign volt_mv   = volt_mv_reg;
    assign curr_ma   = curr_ma_reg;
    assign reject    = reject_reg;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_volt_mv_decode: assert property (volt_mv == olr_pkg::olr_volt_mv(volt_reg[13:2]))
        else $error("voltage decode mismatch");
    a_volt_stays_range: assert property (sel_v && !v_in_rng |=> $stable(volt_reg) && reject)
        else $error("out of range voltage write took effect");
    a_volt_reset_val: assert property ($rose(rstn) |-> volt_reg == 16'h09c4)
        else $error("voltage limit reset value wrong");
    a_rsvd_bad_write: assert property (bus.wr_stb && (v_bad && sel_v || i_bad && sel_i)
                                       |=> $stable(volt_reg) && $stable(curr_reg) && reject)
        else $error("write with reserved ones took effect");
    a_low_bits_ignored: assert property (volt_reg[1:0] == 2'b00 && curr_reg[7:0] == 8'h00)
        else $error("ignored bits were stored");
    a_curr_ma_decode: assert property (curr_ma == 13'(int'(curr_reg[14:8]) * 50))
        else $error("current decode mismatch");
    a_curr_reset_val: assert property ($rose(rstn) |-> curr_reg == 16'h3c00)
        else $error("current limit reset value wrong");
    a_accept_readback: assert property (v_accept ##1 bus.cmd == olr_pkg::OLR_CMD_VOLT
                                        |-> bus.rdata == ($past(bus.wdata) & 16'h3ffc))
        else $error("accepted voltage write not read back");

    c_volt_accept:  cover property (v_accept);
    c_volt_range:   cover property (sel_v && !v_bad && !v_in_rng);
    c_curr_reject:  cover property (sel_i && i_bad);

endmodule

// [verification/olr_smb_host.sv]
// ==========================================================
// bus host model: drives clock and data, reads wired data
// ==========================================================
module olr_smb_host (
    input  wire logic clk,
    input  wire logic sda_oe,
    input  wire logic sda_out,
    output logic      scl,
    output logic      sda_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_drv; // host pull, 1 = released
    // wired-and data line with pull-up; the device shows sda_out while sda_oe is high
    assign sda_wire = sda_drv & (~sda_oe | sda_out);
    // idle bus: both lines released
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bit: 4 clk low, 4 clk high, read mid-high
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_drv <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda_wire;
        tick(2);
        scl <= 1'b0;
    endtask
    // byte msb first, then one answer bit
    task automatic byte_io(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ar);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(a, ar);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        tick(2);
        sda_drv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        tick(2);
        sda_drv <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(4);
    endtask
    // word write, low byte first; nak holds the four answer bits
    task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
                              output logic [3:0] nak);
        logic [7:0] r;
        start();
        byte_io({adr, 1'b0}, 1'b1, r, nak[3]);
        byte_io(cmd, 1'b1, r, nak[2]);
        byte_io(d[7:0], 1'b1, r, nak[1]);
        byte_io(d[15:8], 1'b1, r, nak[0]);
        stop();
    endtask
    // word read: host acks low byte, nacks high byte
    task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd, output logic [15:0] d,
                             output logic [2:0] nak);
        logic [7:0] r;
        logic       x;
        start();
        byte_io({adr, 1'b0}, 1'b1, r, nak[2]);
        byte_io(cmd, 1'b1, r, nak[1]);
        start();
        byte_io({adr, 1'b1}, 1'b1, r, nak[0]);
        byte_io(8'hff, 1'b0, d[7:0], x);
        byte_io(8'hff, 1'b1, d[15:8], x);
        stop();
    endtask
endmodule

// [verification/otg_output_limit_regs_tb.sv]
module otg_output_limit_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    // ==========================================================
    logic        clk;
    logic        rstn;
    logic        scl;
    logic        sda_wire;
    logic        sda_oe;
    logic        sda_out;
    logic [11:0] volt_code;
    logic [6:0]  curr_code;
    logic [14:0] volt_mv;
    logic [12:0] curr_ma;
    logic        rejected;
    int          fails;
    int          cmp_count;
    int          rej_seen = 0; // refusal pulses seen
    int          exp_rej;   // refusals expected
    logic [15:0] exp_v;     // expected voltage word
    logic [15:0] exp_i;     // expected current word
    // command and word per write
    logic [23:0] plan [12] = '{24'h3b0177, 24'h3b05d8, 24'h3b05df, 24'h3b2ee0, 24'h3b2ee4, 24'h3b6ee0,
                               24'h3b85dc, 24'h3c8100, 24'h3c7fff, 24'h3c01aa, 24'h3d1234, 24'h3b0a03};
    olr_top dut (
        .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .otg_volt_code(volt_code), .otg_curr_code(curr_code), .otg_volt_mv(volt_mv),
        .otg_curr_ma(curr_ma), .write_rejected(rejected));
    olr_smb_host host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda_wire(sda_wire));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count one-cycle refusal pulses
    always @(posedge clk) begin
        if (rejected === 1'b1) rej_seen <= rej_seen + 1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // read both registers back and compare outputs
    task automatic verify();
        logic [15:0] rd;
        logic [2:0]  nak;
        host.read_word(olr_pkg::OLR_SLAVE_ADDR, 8'h3b, rd, nak);
        check(nak, 0, "read acks");
        check(rd, exp_v, "voltage word");
        host.read_word(olr_pkg::OLR_SLAVE_ADDR, 8'h3c, rd, nak);
        check(nak, 0, "read acks");
        check(rd, exp_i, "current word");
        check(volt_code, exp_v[13:2], "voltage code");
        check(volt_mv, exp_v[13:2] * 8, "voltage mv");
        check(curr_code, exp_i[14:8], "current code");
        check(curr_ma, exp_i[14:8] * 50, "current ma");
        check(rej_seen, exp_rej, "refusal pulses");
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        logic [3:0]  nak;
        logic [2:0]  rnak;
        logic [15:0] rd;
        logic [15:0] wd;
        logic [7:0]  cmd;
        logic        bad;
        rstn     = 1'b0;
        exp_rej  = 0;
        exp_v    = 16'h09c4;
        exp_i    = 16'h3c00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        verify();
        foreach (plan[k]) begin
            cmd = plan[k][23:16];
            wd  = plan[k][15:0];
            host.write_word(olr_pkg::OLR_SLAVE_ADDR, cmd, wd, nak);
            check(nak, 4'h0, "write acks");
            // expected outcome worked out from the field rules
            if (cmd == 8'h3b) begin
                bad = (wd[15:14] != 2'b00) || (wd[13:2] * 8 < 3000) || (wd[13:2] * 8 > 24000);
                if (bad) exp_rej++;
                else exp_v = wd & 16'h3ffc;
            end else if (cmd == 8'h3c) begin
                if (wd[15]) exp_rej++;
                else exp_i = wd & 16'h7f00;
            end
            verify();
        end
        // foreign address: no answer, nothing stored
        host.write_word(olr_pkg::OLR_SLAVE_ADDR ^ 7'h01, 8'h3b, 16'h2ee0, nak);
        check(nak[3], 1'b1, "foreign address answered");
        verify();
        // unmapped command reads zero
        host.read_word(olr_pkg::OLR_SLAVE_ADDR, 8'h3d, rd, rnak);
        check(rnak, 0, "unmapped read acks");
        check(rd, 16'h0000, "unmapped read");
        // reset in mid-run brings both limits back to their defaults
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        exp_v = 16'h09c4;
        exp_i = 16'h3c00;
        verify();
        wrap_up();
    end
    // hang guard, well beyond the expected run
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up();
    end
endmodule
